/* File: src/ttc_cfg.svh */
// Constants for the trace trigger and capture block
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define TTC_REG_CTRL 4'h0
`define TTC_REG_STATUS 4'h1
`define TTC_REG_CMPA 4'h2
`define TTC_REG_CMPB 4'h3
`define TTC_REG_CMPC 4'h4
`define TTC_REG_WINDOW 4'h5
`define TTC_REG_COUNT 4'h6

// ****************************************
// Control field positions
// ****************************************
`define TTC_CTRL_EN 0
`define TTC_CTRL_ARM 1
`define TTC_CTRL_TAG 2
`define TTC_CTRL_BEGIN 3
`define TTC_CTRL_CAP_LO 4
`define TTC_CTRL_CAP_HI 5
`define TTC_CTRL_RWENA 6
`define TTC_CTRL_RWA 7
`define TTC_CTRL_RWENB 8
`define TTC_CTRL_RWB 9
`define TTC_CTRL_TRG_LO 12
`define TTC_CTRL_TRG_HI 15

// ****************************************
// Field codes and reset values
// ****************************************
`define TTC_CAP_NORMAL 2'h0
`define TTC_CAP_LOOP1 2'h1
`define TTC_CAP_DETAIL 2'h2
`define TTC_CAP_PROFILE 2'h3
`define TTC_TRG_A_ONLY 4'h0
`define TTC_TRG_A_OR_B 4'h1
`define TTC_TRG_A_THEN_B 4'h2
`define TTC_TRG_EVT_B 4'h3
`define TTC_TRG_A_THEN_EVT_B 4'h4
`define TTC_TRG_A_AND_B 4'h5
`define TTC_TRG_A_AND_NOT_B 4'h6
`define TTC_TRG_INSIDE 4'h7
`define TTC_TRG_OUTSIDE 4'h8
`define TTC_RST_CTRL 16'h0000
`define TTC_RST_CMP 16'h0000
`define TTC_INVALID_READ 16'hFFFF
`define TTC_DEPTH 64

`endif

/* File: src/ttc_pkg.sv */
// Types shared by the trace trigger and capture block
package ttc_pkg;
	typedef enum logic [3:0] {
		TRG_A_ONLY, TRG_A_OR_B, TRG_A_THEN_B, TRG_EVT_B, TRG_A_THEN_EVT_B,
		TRG_A_AND_B, TRG_A_AND_NOT_B, TRG_INSIDE, TRG_OUTSIDE, TRG_B_ONLY
	} ttc_trg_t;
	typedef enum logic [1:0] {CAP_NORMAL, CAP_LOOP1, CAP_DETAIL, CAP_PROFILE} ttc_cap_t;
	typedef enum logic [1:0] {COF_SOURCE, COF_DEST, COF_VECTOR} ttc_cof_t;
endpackage

/* File: src/ttc_trace_trigger_capture.sv */
// Trace trigger, capture and trace RAM of the on-chip debug unit
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"

module ttc_trace_trigger_capture #(
	parameter int DEPTH = `TTC_DEPTH,
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] regAddr,
	input wire logic [WIDTH-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [WIDTH-1:0] regRdData,
	input wire logic busValid,
	input wire logic [WIDTH-1:0] busAddr,
	input wire logic [WIDTH-1:0] busData,
	input wire logic busRead,
	input wire logic busWord,
	input wire logic busFetch,
	input wire logic busFree,
	input wire logic ramSingleCycle,
	input wire logic execValid,
	input wire logic [WIDTH-1:0] execAddr,
	input wire logic cofValid,
	input wire ttc_pkg::ttc_cof_t cofKind,
	input wire logic [WIDTH-1:0] cofAddr,
	input wire logic cofExcluded,
	output logic triggerPulse,
	output logic armedOut
);
	import ttc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [CW-1:0] ONE = CW'(1);
	localparam logic [CW-1:0] TWO = CW'(2);

	// ****************************************
	// State
	// ****************************************
	logic [WIDTH-1:0] ram [DEPTH];
	logic [WIDTH-1:0] ctrl, cmpA, cmpB, cmpC, lastExec;
	logic armed, triggered, aSeen, flagA, flagB, flagC, cValid;
	logic [AW-1:0] wrPtr, rdPtr;
	logic [CW-1:0] count;
	logic [WIDTH-1:0] next_ctrl, next_cmpA, next_cmpB, next_cmpC, next_lastExec;
	logic next_armed, next_triggered, next_aSeen, next_flagA, next_flagB;
	logic next_flagC, next_cValid, next_triggerPulse;
	logic [AW-1:0] next_wrPtr, next_rdPtr;
	logic [CW-1:0] next_count;
	logic [WIDTH-1:0] next_regRdData;

	// ****************************************
	// Decoded controls and compare results
	// ****************************************
	ttc_cap_t capMode;
	ttc_trg_t mode;
	logic enable, tagSel, beginSel, evtOnly, beginEff, fullMode, active;
	logic rwOkA, rwOkB, mA, mB, dataMatch, inRange, belowA, aboveB;
	logic rValid, setA, setB, trig;
	logic [WIDTH-1:0] rAddr, loW, hiW;
	logic storeOne, storeTwo, cofOk, dupSource, canStore;
	logic [WIDTH-1:0] storeWord0, storeWord1;

	assign enable = ctrl[`TTC_CTRL_EN];
	assign tagSel = ctrl[`TTC_CTRL_TAG];
	assign beginSel = ctrl[`TTC_CTRL_BEGIN];

	// Field decode; unused trigger codes fall back to A only
	always_comb begin
		unique case (ctrl[`TTC_CTRL_CAP_HI:`TTC_CTRL_CAP_LO])
			`TTC_CAP_NORMAL: capMode = CAP_NORMAL;
			`TTC_CAP_LOOP1: capMode = CAP_LOOP1;
			`TTC_CAP_DETAIL: capMode = CAP_DETAIL;
			`TTC_CAP_PROFILE: capMode = CAP_PROFILE;
		endcase
		case (ctrl[`TTC_CTRL_TRG_HI:`TTC_CTRL_TRG_LO])
			`TTC_TRG_A_OR_B: mode = TRG_A_OR_B;
			`TTC_TRG_A_THEN_B: mode = TRG_A_THEN_B;
			`TTC_TRG_EVT_B: mode = TRG_EVT_B;
			`TTC_TRG_A_THEN_EVT_B: mode = TRG_A_THEN_EVT_B;
			`TTC_TRG_A_AND_B: mode = TRG_A_AND_B;
			`TTC_TRG_A_AND_NOT_B: mode = TRG_A_AND_NOT_B;
			`TTC_TRG_INSIDE: mode = TRG_INSIDE;
			`TTC_TRG_OUTSIDE: mode = TRG_OUTSIDE;
			default: mode = TRG_A_ONLY;
		endcase
		// Detail capture outranks the event-only modes
		if (capMode == CAP_DETAIL && mode == TRG_EVT_B) begin
			mode = TRG_B_ONLY;
		end else if (capMode == CAP_DETAIL && mode == TRG_A_THEN_EVT_B) begin
			mode = TRG_A_THEN_B;
		end
	end

	assign evtOnly = (mode == TRG_EVT_B) || (mode == TRG_A_THEN_EVT_B);
	assign beginEff = beginSel || evtOnly;
	assign fullMode = (mode == TRG_A_AND_B) || (mode == TRG_A_AND_NOT_B);
	assign active = armed && enable && capMode != CAP_PROFILE;

	// Read/write qualification; full modes use the A enable for both
	always_comb begin
		if (tagSel) begin
			rwOkA = 1'b1;
			rwOkB = 1'b1;
		end else begin
			rwOkA = !ctrl[`TTC_CTRL_RWENA] || (ctrl[`TTC_CTRL_RWA] == busRead);
			rwOkB = !ctrl[`TTC_CTRL_RWENB] || (ctrl[`TTC_CTRL_RWB] == busRead);
			if (fullMode) begin
				rwOkB = rwOkA;
			end
		end
	end

	// Tagged compares look at the opcode about to execute, forced ones at the bus
	always_comb begin
		if (tagSel) begin
			mA = execValid && execAddr == cmpA;
		end else begin
			mA = busValid && rwOkA && busAddr == cmpA;
		end
		// Event-only B is never tagged outside detail capture
		if (tagSel && !evtOnly) begin
			mB = execValid && execAddr == cmpB;
		end else begin
			mB = busValid && rwOkB && busAddr == cmpB;
		end
	end

	// Misaligned word data compare only works on single-cycle RAM
	assign dataMatch = busValid && rwOkA && busData == cmpB
		&& !(busWord && busAddr[0] && !ramSingleCycle);

	// Range compares: word granular when tagged, exact bus address when forced
	always_comb begin
		if (tagSel) begin
			rValid = execValid;
			rAddr = {execAddr[WIDTH-1:1], 1'b0};
			loW = {cmpA[WIDTH-1:1], 1'b0};
			hiW = {cmpB[WIDTH-1:1], 1'b0};
		end else begin
			rValid = busValid && rwOkA;
			rAddr = busAddr;
			loW = cmpA;
			hiW = cmpB;
		end
	end

	assign inRange = rValid && rAddr >= loW && rAddr <= hiW;
	assign belowA = rValid && rAddr < loW;
	assign aboveB = rValid && rAddr > hiW;

	// Trigger decision per mode; only meaningful while active
	always_comb begin
		setA = 1'b0;
		setB = 1'b0;
		trig = 1'b0;
		unique case (mode)
			TRG_A_ONLY: begin
				setA = mA;
				trig = mA;
			end
			TRG_A_OR_B: begin
				setA = mA;
				setB = mB;
				trig = mA || mB;
			end
			TRG_A_THEN_B, TRG_A_THEN_EVT_B: begin
				setA = mA;
				setB = aSeen && mB;
				trig = aSeen && mB;
			end
			TRG_B_ONLY, TRG_EVT_B: begin
				setB = mB;
				trig = mB;
			end
			TRG_A_AND_B, TRG_A_AND_NOT_B: begin
				if (tagSel) begin
					setA = mA;
					trig = mA;
				end else begin
					// Same bus cycle: A and B wants a data hit, A and not B a miss
					setA = mA && (dataMatch != (mode == TRG_A_AND_NOT_B));
					setB = setA;
					trig = setA;
				end
			end
			TRG_INSIDE: begin
				setA = inRange;
				setB = inRange;
				trig = inRange;
			end
			TRG_OUTSIDE: begin
				setA = belowA;
				setB = aboveB;
				trig = belowA || aboveB;
			end
		endcase
		// Begin mode ignores later triggers except repeated data events
		if (!active || (beginEff && triggered && !evtOnly)) begin
			setA = 1'b0;
			setB = 1'b0;
			trig = 1'b0;
		end
	end

	// ****************************************
	// Storage selection
	// ****************************************
	// Loop1 compares only the unpaged address, so paged loops may alias
	assign dupSource = capMode == CAP_LOOP1 && cofKind == COF_SOURCE
		&& cValid && cofAddr == cmpC;
	assign cofOk = cofValid && !cofExcluded && !dupSource;
	assign canStore = beginEff ? (triggered || trig) : !trig;

	always_comb begin
		storeOne = 1'b0;
		storeTwo = 1'b0;
		storeWord0 = cofAddr;
		storeWord1 = busData;
		if (active && canStore) begin
			if (capMode == CAP_DETAIL) begin
				// Address then data; pairs keep the count even
				storeTwo = busValid && !busFetch && !busFree;
				storeWord0 = busAddr;
			end else if (evtOnly) begin
				storeOne = trig;
				storeWord0 = busData;
			end else begin
				storeOne = cofOk;
			end
		end
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_ctrl = ctrl;
		next_cmpA = cmpA;
		next_cmpB = cmpB;
		next_cmpC = cmpC;
		next_cValid = cValid;
		next_armed = armed;
		next_triggered = triggered || trig;
		next_aSeen = aSeen || (active && mA);
		next_flagA = flagA || setA;
		next_flagB = flagB || setB;
		next_flagC = flagC;
		next_wrPtr = wrPtr;
		next_count = count;
		next_rdPtr = rdPtr;
		next_lastExec = execValid ? execAddr : lastExec;
		next_triggerPulse = trig;
		next_regRdData = '0;
		// Comparator C flag; it serves as the loop filter in loop1
		if (enable && capMode != CAP_LOOP1 && busValid && busAddr == cmpC) begin
			next_flagC = 1'b1;
		end
		// Write position and count; count saturates at the depth
		if (storeOne) begin
			next_wrPtr = AW'(wrPtr + 1'b1);
			next_count = (count == FULL) ? FULL : count + ONE;
		end else if (storeTwo) begin
			next_wrPtr = AW'(wrPtr + 2'd2);
			next_count = (count >= FULL - ONE) ? FULL : count + TWO;
		end
		// Loop1 remembers the last stored address to drop repeated branch sources
		if (storeOne && capMode == CAP_LOOP1) begin
			next_cmpC = storeWord0;
			next_cValid = 1'b1;
		end
		// Disarm on full in begin mode, or at the trigger in end mode
		if (active && (beginEff ? (next_count == FULL && next_triggered) : trig)) begin
			next_armed = 1'b0;
		end
		// Register reads
		if (regRd) begin
			unique case (regAddr)
				`TTC_REG_CTRL: next_regRdData = {ctrl[WIDTH-1:2], armed, ctrl[0]};
				`TTC_REG_STATUS: next_regRdData = WIDTH'({triggered, armed, flagC,
					flagB, flagA});
				`TTC_REG_CMPA: next_regRdData = cmpA;
				`TTC_REG_CMPB: next_regRdData = cmpB;
				`TTC_REG_CMPC: next_regRdData = cmpC;
				`TTC_REG_COUNT: next_regRdData = WIDTH'(count);
				`TTC_REG_WINDOW: begin
					if (capMode == CAP_PROFILE) begin
						next_regRdData = lastExec;
					end else if (armed) begin
						next_regRdData = `TTC_INVALID_READ;
					end else begin
						next_regRdData = ram[rdPtr];
						next_rdPtr = AW'(rdPtr + 1'b1);
					end
				end
				default: next_regRdData = '0;
			endcase
		end
		// Register writes; a software arm restarts the whole capture
		if (regWr) begin
			unique case (regAddr)
				`TTC_REG_CTRL: begin
					next_ctrl = regWrData;
					// Profile leaves the arm bit unused, so it never arms
					next_armed = regWrData[`TTC_CTRL_ARM] && regWrData[`TTC_CTRL_EN]
						&& regWrData[`TTC_CTRL_CAP_HI:`TTC_CTRL_CAP_LO] != `TTC_CAP_PROFILE;
					if (regWrData[`TTC_CTRL_ARM]) begin
						next_flagA = 1'b0;
						next_flagB = 1'b0;
						next_flagC = 1'b0;
						next_triggered = 1'b0;
						next_aSeen = 1'b0;
						next_wrPtr = '0;
						next_count = '0;
						if (regWrData[`TTC_CTRL_CAP_HI:`TTC_CTRL_CAP_LO] == `TTC_CAP_LOOP1) begin
							next_cmpC = `TTC_RST_CMP;
							next_cValid = 1'b0;
						end
					end
				end
				`TTC_REG_CMPA: next_cmpA = regWrData;
				`TTC_REG_CMPB: next_cmpB = regWrData;
				`TTC_REG_CMPC: begin
					next_cmpC = regWrData;
					next_cValid = 1'b0;
				end
				default: next_ctrl = ctrl;
			endcase
		end
		// While armed the read pointer tracks the oldest word for FIFO readout
		if (next_armed) begin
			next_rdPtr = AW'(next_wrPtr - next_count[AW-1:0]);
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= `TTC_RST_CTRL;
			cmpA <= `TTC_RST_CMP;
			cmpB <= `TTC_RST_CMP;
			cmpC <= `TTC_RST_CMP;
			lastExec <= '0;
			cValid <= 1'b0;
			armed <= 1'b0;
			triggered <= 1'b0;
			aSeen <= 1'b0;
			flagA <= 1'b0;
			flagB <= 1'b0;
			flagC <= 1'b0;
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			regRdData <= '0;
			triggerPulse <= 1'b0;
			armedOut <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			cmpA <= next_cmpA;
			cmpB <= next_cmpB;
			cmpC <= next_cmpC;
			lastExec <= next_lastExec;
			cValid <= next_cValid;
			armed <= next_armed;
			triggered <= next_triggered;
			aSeen <= next_aSeen;
			flagA <= next_flagA;
			flagB <= next_flagB;
			flagC <= next_flagC;
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			regRdData <= next_regRdData;
			triggerPulse <= next_triggerPulse;
			armedOut <= next_armed;
		end
	end

	// Trace RAM; no reset, contents are only valid up to the count
	always_ff @(posedge clk) begin
		if (storeOne || storeTwo) begin
			ram[wrPtr] <= storeWord0;
		end
		if (storeTwo) begin
			ram[AW'(wrPtr + 1'b1)] <= storeWord1;
		end
	end

endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the trace trigger and capture block
`timescale 1ns/1ps
`default_nettype none
`include "ttc_cfg.svh"
module testbench;
	import ttc_pkg::*;
	localparam logic [9:0] RDC = 10'h003; // Plain read cycle
	localparam logic [9:0] RDW = 10'h007; // Full-word read
	localparam logic [9:0] COF = 10'h023; // Taken branch source
	localparam logic [9:0] COFD = 10'h123; // Jump or return target
	localparam logic [9:0] VEXC = 10'h2A3; // Excluded vector
	localparam logic [9:0] EXE = 10'h040; // Opcode about to run
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdData, busAddr, busData, execAddr, cofAddr;
	logic busValid, busRead, busWord, busFetch, busFree, ramSingleCycle;
	logic execValid, cofValid, cofExcluded, triggerPulse, armedOut;
	ttc_cof_t cofKind;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	// 125 MHz core clock
	always #4 clk = ~clk;
	ttc_trace_trigger_capture uut (.*);
	ttc_bus_model bus (.*);
	// Cut a hang short; the whole run needs under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			report_and_stop();
		end
	end
	// ****************************************
	// Access tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
	endtask
	// Bus cycle, then the one-cycle trigger pulse that should follow it
	task automatic bc(input logic [15:0] a, input logic [15:0] d, input logic [9:0] c,
		input logic t);
		bus.cyc(a, d, c);
		#1 chk({15'h0000, triggerPulse}, {15'h0000, t});
	endtask
	function automatic logic [15:0] cw(input logic [3:0] t, input logic [1:0] m,
		input logic b, input logic g, input logic arm);
		return {t, 6'h00, m, b, g, arm, 1'b1};
	endfunction
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			if (i != 5) begin
				rd(4'(i), 16'h0000);
			end
		end
		$display("reset values done");
		wr(2, 16'h1234);
		wr(0, cw(`TTC_TRG_A_ONLY, `TTC_CAP_NORMAL, 1, 0, 1));
		rd(5, 16'hFFFF);
		bc(16'h1200, 16'h0000, COF, 0);
		bc(16'h1234, 16'h0000, COF, 1);
		bc(16'h7000, 16'h0000, VEXC, 0);
		for (int i = 1; i < 64; i++) begin
			bc(16'h2000 + 16'(i), 16'h0000, COF, 0);
		end
		rd(6, 16'h0040);
		rd(1, 16'h0011);
		rd(5, 16'h1234);
		rd(5, 16'h2001);
		$display("begin capture done");
		wr(3, 16'h55AA);
		wr(0, cw(`TTC_TRG_A_AND_NOT_B, `TTC_CAP_NORMAL, 0, 0, 1));
		bc(16'h1234, 16'h55AA, RDW, 0);
		bc(16'h1234, 16'h0001, RDW, 1);
		rd(1, 16'h0013);
		wr(2, 16'h1235);
		bus.fast(1);
		wr(0, cw(`TTC_TRG_A_AND_NOT_B, `TTC_CAP_NORMAL, 0, 0, 1));
		bc(16'h1235, 16'h55AA, RDW, 0);
		bus.fast(0);
		bc(16'h1235, 16'h55AA, RDW, 1);
		wr(0, cw(`TTC_TRG_A_AND_B, `TTC_CAP_NORMAL, 0, 1, 1));
		bc(16'h1235, 16'h0000, EXE, 1);
		$display("full modes done");
		wr(2, 16'h1000);
		wr(3, 16'h1FFF);
		wr(0, cw(`TTC_TRG_INSIDE, `TTC_CAP_NORMAL, 0, 0, 1));
		bc(16'h0FFF, 16'h0000, RDC, 0);
		bc(16'h2000, 16'h0000, RDC, 0);
		rd(1, 16'h0008);
		bc(16'h1800, 16'h0000, RDC, 1);
		rd(1, 16'h0013);
		wr(0, cw(`TTC_TRG_OUTSIDE, `TTC_CAP_NORMAL, 0, 0, 1));
		bc(16'h1800, 16'h0000, RDC, 0);
		bc(16'h2000, 16'h0000, RDC, 1);
		rd(1, 16'h0012);
		$display("range modes done");
		wr(3, 16'h3000);
		wr(0, cw(`TTC_TRG_EVT_B, `TTC_CAP_NORMAL, 0, 1, 1));
		bc(16'h3000, 16'hBEEF, RDC, 1);
		rd(6, 16'h0001);
		wr(0, cw(`TTC_TRG_EVT_B, `TTC_CAP_NORMAL, 0, 1, 0));
		rd(5, 16'hBEEF);
		wr(3, 16'h4000);
		wr(0, cw(`TTC_TRG_EVT_B, `TTC_CAP_DETAIL, 1, 0, 1));
		bc(16'h4000, 16'h1111, RDC, 1);
		bc(16'h4002, 16'h9999, 10'h00B, 0);
		bc(16'h4004, 16'h9998, 10'h013, 0);
		bc(16'h4006, 16'h2222, 10'h001, 0);
		wr(0, cw(`TTC_TRG_EVT_B, `TTC_CAP_DETAIL, 1, 0, 0));
		rd(5, 16'h4000);
		rd(5, 16'h1111);
		rd(5, 16'h4006);
		rd(5, 16'h2222);
		$display("event and detail done");
		wr(4, 16'h9999);
		wr(2, 16'h5000);
		wr(0, cw(`TTC_TRG_A_ONLY, `TTC_CAP_LOOP1, 1, 0, 1));
		rd(4, 16'h0000);
		bc(16'h5000, 16'h0000, RDC, 1);
		bc(16'h5100, 16'h0000, COF, 0);
		bc(16'h5100, 16'h0000, COF, 0);
		bc(16'h6000, 16'h0000, COFD, 0);
		bc(16'h6000, 16'h0000, COFD, 0);
		bc(16'h7000, 16'h0000, VEXC, 0);
		rd(6, 16'h0003);
		rd(4, 16'h6000);
		$display("loop1 done");
		wr(3, 16'h3000);
		wr(0, cw(`TTC_TRG_A_OR_B, `TTC_CAP_NORMAL, 1, 0, 1) | 16'h0040);
		bc(16'h5000, 16'h0000, RDC, 0);
		bc(16'h3000, 16'h0000, RDC, 1);
		rd(1, 16'h001A);
		wr(0, cw(`TTC_TRG_A_ONLY, `TTC_CAP_NORMAL, 0, 1, 1) | 16'h00C0);
		bc(16'h5000, 16'h0000, EXE, 1);
		wr(0, cw(`TTC_TRG_A_THEN_EVT_B, `TTC_CAP_NORMAL, 0, 0, 1));
		bc(16'h3000, 16'h0001, RDC, 0);
		bc(16'h5000, 16'h0000, RDC, 0);
		bc(16'h3000, 16'h0002, RDC, 1);
		bc(16'h3000, 16'h0003, RDC, 1);
		rd(6, 16'h0002);
		rd(1, 16'h001B);
		$display("qualifier and sequence modes done");
		wr(0, cw(`TTC_TRG_A_ONLY, `TTC_CAP_PROFILE, 0, 0, 1));
		bc(16'hABCD, 16'h0000, EXE, 0);
		rd(5, 16'hABCD);
		rd(5, 16'hABCD);
		chk({15'h0000, armedOut}, 16'h0000);
		$display("profile done");
		report_and_stop();
	end
endmodule
`default_nettype wire

/* File: verif/ttc_bus_model.sv */
// Core bus model that feeds the trace block
`timescale 1ns/1ps
`default_nettype none
module ttc_bus_model (
	input wire logic clk,
	output logic busValid,
	output logic [15:0] busAddr,
	output logic [15:0] busData,
	output logic busRead,
	output logic busWord,
	output logic busFetch,
	output logic busFree,
	output logic ramSingleCycle,
	output logic execValid,
	output logic [15:0] execAddr,
	output logic cofValid,
	output var ttc_pkg::ttc_cof_t cofKind,
	output logic [15:0] cofAddr,
	output logic cofExcluded
);
	import ttc_pkg::*;
	logic [7:0] ctl;
	// Qualifier bits, low bit first: valid, read, word, fetch, free, cof, exec, excluded
	assign {cofExcluded, execValid, cofValid, busFree, busFetch, busWord, busRead, busValid} = ctl;
	// Quiet bus at time zero
	initial begin
		ctl = 8'h00;
		{busAddr, busData, execAddr, cofAddr} = 64'h0000_0000_0000_0000;
		ramSingleCycle = 1'b0;
		cofKind = COF_SOURCE;
	end
	// Whether the target memory completes misaligned words in one cycle
	task automatic fast(input logic f);
		@(posedge clk);
		ramSingleCycle <= f;
	endtask
	// One core cycle; c[9:8] is the record kind
	task automatic cyc(input logic [15:0] a, input logic [15:0] d, input logic [9:0] c);
		@(posedge clk);
		ctl <= c[7:0];
		cofKind <= ttc_cof_t'(c[9:8]);
		{busAddr, execAddr, cofAddr} <= {3{a}};
		busData <= d;
		@(posedge clk);
		// Released lines show the inverse, so a stale value never matches by luck
		ctl <= 8'h00;
		{busAddr, execAddr, cofAddr} <= {3{~a}};
		busData <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: verif/ttc_checker_properties.sv */
// Port properties of the trace trigger and capture block
`timescale 1ns/1ps
`default_nettype none
module ttc_checker #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] regAddr,
	input wire logic [WIDTH-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [WIDTH-1:0] regRdData,
	input wire logic busValid,
	input wire logic execValid,
	input wire logic [WIDTH-1:0] execAddr,
	input wire logic triggerPulse,
	input wire logic armedOut
);
	logic ctrlWr;
	logic [1:0] capMode, next_capMode;
	logic [WIDTH-1:0] lastExec, next_lastExec;
	assign ctrlWr = regWr && regAddr == 4'h0;
	// Shadow of the capture field and of the last opcode address
	always_comb begin
		next_capMode = ctrlWr ? regWrData[5:4] : capMode;
		next_lastExec = execValid ? execAddr : lastExec;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			capMode <= 2'h0;
			lastExec <= '0;
		end else begin
			capMode <= next_capMode;
			lastExec <= next_lastExec;
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == '0)
		else $error("read data not zero outside a read answer");
	unmapped_rd_a: assert property (regRd && regAddr > 4'h6 |=> regRdData == '0)
		else $error("unmapped read not zero");
	arm_sets_a: assert property (ctrlWr && regWrData[1:0] == 2'h3
		&& regWrData[5:4] != 2'h3 |=> ##[0:1] armedOut)
		else $error("arm write did not arm");
	disarm_clears_a: assert property (ctrlWr && !regWrData[1] |=> !armedOut)
		else $error("disarm write left unit armed");
	window_armed_a: assert property ((regRd && regAddr == 4'h5 && armedOut
		&& capMode != 2'h3 ##1 armedOut) |-> regRdData == '1)
		else $error("armed window read not invalid");
	trig_cause_a: assert property (triggerPulse
		|-> $past(busValid || execValid) && ($past(armedOut) || $past(armedOut, 2)))
		else $error("trigger without armed bus activity");
	profile_read_a: assert property (capMode == 2'h3 && regRd && regAddr == 4'h5
		&& !execValid |=> regRdData == $past(lastExec))
		else $error("profile read not last opcode");
	status_armed_a: assert property ((regRd && regAddr == 4'h1 && armedOut
		##1 armedOut) |-> regRdData[3])
		else $error("status armed bit low while armed");
endmodule
bind ttc_trace_trigger_capture ttc_checker #(.WIDTH(WIDTH)) chk (.*);
`default_nettype wire
